// File: inc/uifc_pkg.sv
// Package for the UART interrupt and FIFO control block
package uifc_pkg;
	localparam int FIFO_DEPTH = 128;
	localparam int CNT_W = 8;
	// FIFO setup and feature trigger control fields
	localparam int FSC_EN = 0;
	localparam int FSC_RXRST = 1;
	localparam int FSC_TXRST = 2;
	localparam int FSC_WAKE = 3;
	localparam int FSC_TXTRG_LO = 4;
	localparam int FSC_RXTRG_LO = 6;
	localparam int FTC_TBL_LO = 4;
	localparam int FTC_TRGSEL = 7;
	// Status codes, bits 5:0
	localparam logic [5:0] CODE_LINE = 6'h06;
	localparam logic [5:0] CODE_RXTO = 6'h0c;
	localparam logic [5:0] CODE_RX_READY = 6'h04;
	localparam logic [5:0] CODE_TX_READY = 6'h02;
	localparam logic [5:0] CODE_MODEM = 6'h00;
	localparam logic [5:0] CODE_CHAR = 6'h10;
	localparam logic [5:0] CODE_FLOW = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;
	// Timeout: 4 characters plus 12 bits
	localparam int TO_CHARS = 4;
	localparam int TO_BITS = 12;
	typedef enum logic [1:0] {TBL_A = 2'h0, TBL_B = 2'h1, TBL_C = 2'h2, TBL_D = 2'h3} uifc_tbl_t;
	typedef enum logic [2:0] {
		TO_IDLE = 3'h1,
		TO_RUN = 3'h2,
		TO_FIRED = 3'h4
	} uifc_to_state_t;
endpackage

// File: inc/uifc_trig_if.sv
// Trigger level carrier between control and lookup
`timescale 1ns/1ps
interface uifc_trig_if;
	logic [1:0] table_sel;
	logic [1:0] rx_field;
	logic [1:0] tx_field;
	logic [7:0] rx_prog;
	logic [7:0] tx_prog;
	logic [7:0] rx_level;
	logic [7:0] tx_level;
	modport ctrl (output table_sel, rx_field, tx_field, rx_prog, tx_prog, input rx_level, tx_level);
	modport lut (input table_sel, rx_field, tx_field, rx_prog, tx_prog, output rx_level, tx_level);
endinterface

// File: hdl/uifc_trig_lut.sv
// Trigger table lookup
`timescale 1ns/1ps
module uifc_trig_lut
(
	uifc_trig_if.lut t
);
	always_comb
	begin
		case (t.table_sel)
			uifc_pkg::TBL_A:
			begin
				case (t.rx_field)
					2'h0: t.rx_level = 8'h01;
					2'h1: t.rx_level = 8'h04;
					2'h2: t.rx_level = 8'h08;
					default: t.rx_level = 8'h0e;
				endcase
				t.tx_level = 8'h01;
			end
			uifc_pkg::TBL_B:
			begin
				case (t.rx_field)
					2'h0: t.rx_level = 8'h08;
					2'h1: t.rx_level = 8'h10;
					2'h2: t.rx_level = 8'h18;
					default: t.rx_level = 8'h1c;
				endcase
				case (t.tx_field)
					2'h0: t.tx_level = 8'h10;
					2'h1: t.tx_level = 8'h08;
					2'h2: t.tx_level = 8'h18;
					default: t.tx_level = 8'h1e;
				endcase
			end
			uifc_pkg::TBL_C:
			begin
				case (t.rx_field)
					2'h0: t.rx_level = 8'h08;
					2'h1: t.rx_level = 8'h10;
					2'h2: t.rx_level = 8'h38;
					default: t.rx_level = 8'h3c;
				endcase
				case (t.tx_field)
					2'h0: t.tx_level = 8'h08;
					2'h1: t.tx_level = 8'h10;
					2'h2: t.tx_level = 8'h20;
					default: t.tx_level = 8'h38;
				endcase
			end
			default:
			begin
				t.rx_level = t.rx_prog;
				t.tx_level = t.tx_prog;
			end
		endcase
	end
endmodule

// File: hdl/uifc_top.sv
// Interrupt prioritiser and FIFO setup control of the UART
// Function
// - Line status interrupt from status bits 1-4; cleared by line status read.
// - Receive ready at trigger level; clears when count drops below it.
// - Receive timeout after 4 chars plus 12 bits; cleared by holding read.
// - Transmit ready from trigger or empty; cleared by status read or write.
// - Modem interrupt from modem bits 0-3; cleared by modem status read.
// - Character match interrupt; special match also clears on next character.
// - Flow change on CTS or RTS rising edge; cleared by modem read.
// - Wakeup interrupt when enabled by setup bit 3; cleared by status read.
// - GPIO interrupt on enabled, polarity-adjusted input; cleared by level read.
// - Highest pending source encoded in status bits 5:0, none reads 000001.
// - Only highest source shown; lower ones stay queued.
// - Status bit 0 low while an encoded source is pending, high when none is (even with wakeup or GPIO pending) and after reset.
// - Bits 4 and 5 only driven with enhanced features enabled.
// - Bit 6 inverts bit 7 while GPIO interrupt pending, else equals it.
// - Bit 7 shows FIFO enable.
// - Setup bit 0 enables FIFOs; other bits ignored unless it is set.
// - Setup bits 1 and 2 reset receive or transmit FIFO pointers.
// - Transmit trigger interrupts below level, or on empty after short reload.
// - Receive trigger field selects level crossed by the count.
// - One trigger table serves both directions; last write wins.
// - Table A and B levels as listed.
// - Table C levels, table D from programmable trigger register.
`timescale 1ns/1ps
module uifc_top
#(
	parameter int GPIO_W = 4
)
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_enh_features,
	input wire logic i_fsc_wr,
	input wire logic [7:0] i_fsc_data,
	input wire logic i_ftc_wr,
	input wire logic [7:0] i_ftc_data,
	input wire logic i_trig_level_wr,
	input wire logic [7:0] i_trig_level_data,
	input wire logic i_iss_rd,
	input wire logic i_line_status_rd,
	input wire logic i_modem_status_rd,
	input wire logic i_rx_holding_rd,
	input wire logic i_tx_holding_wr,
	input wire logic i_gpio_lvl_rd,
	input wire logic [4:1] i_line_status,
	input wire logic [3:0] i_modem_status,
	input wire logic [7:0] i_rx_count,
	input wire logic [7:0] i_tx_count,
	input wire logic i_rx_char,
	input wire logic i_bit_tick,
	input wire logic [3:0] i_char_bits,
	input wire logic i_xonoff_match,
	input wire logic i_special_match,
	input wire logic i_auto_cts,
	input wire logic i_auto_rts,
	input wire logic i_cts,
	input wire logic i_rts,
	input wire logic i_wakeup,
	input wire logic [GPIO_W-1:0] i_gpio,
	input wire logic [GPIO_W-1:0] i_gpio_polarity_invert,
	input wire logic [GPIO_W-1:0] i_gpio_irq_enable,
	output logic [7:0] o_interrupt_source_status,
	output logic o_irq_n,
	output logic o_fifo_en,
	output logic o_rx_fifo_rst,
	output logic o_tx_fifo_rst,
	output logic [7:0] o_rx_trig_level,
	output logic [7:0] o_tx_trig_level
);
	initial
	begin
		if (GPIO_W < 1 || GPIO_W > 16)
			$error("GPIO_W out of range");
	end

	uifc_trig_if trig ();
	uifc_trig_lut u_lut (.t(trig));

	logic fen_q, wake_en_q, rst_rx_q, rst_tx_q, ftc_sel_q;
	logic [1:0] tbl_q, rxf_q, txf_q, ftc_tbl_q;
	logic [7:0] rxp_q, txp_q;

	// FIFO setup writes
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			fen_q <= 1'b0;
			wake_en_q <= 1'b0;
			rxf_q <= 2'h0;
			txf_q <= 2'h0;
			tbl_q <= 2'h0;
			rst_rx_q <= 1'b0;
			rst_tx_q <= 1'b0;
		end
		else
		begin
			rst_rx_q <= 1'b0;
			rst_tx_q <= 1'b0;
			if (i_fsc_wr)
			begin
				fen_q <= i_fsc_data[uifc_pkg::FSC_EN];
				if (i_fsc_data[uifc_pkg::FSC_EN])
				begin
					rst_rx_q <= i_fsc_data[uifc_pkg::FSC_RXRST];
					rst_tx_q <= i_fsc_data[uifc_pkg::FSC_TXRST];
					rxf_q <= i_fsc_data[uifc_pkg::FSC_RXTRG_LO +: 2];
					tbl_q <= ftc_tbl_q;
					if (i_enh_features)
					begin
						wake_en_q <= i_fsc_data[uifc_pkg::FSC_WAKE];
						txf_q <= i_fsc_data[uifc_pkg::FSC_TXTRG_LO +: 2];
					end
				end
			end
			else if (i_ftc_wr)
				tbl_q <= i_ftc_data[uifc_pkg::FTC_TBL_LO +: 2];
		end
	end

	// Feature trigger and programmable levels
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ftc_tbl_q <= 2'h0;
			ftc_sel_q <= 1'b0;
			rxp_q <= 8'h01;
			txp_q <= 8'h01;
		end
		else
		begin
			if (i_ftc_wr)
			begin
				ftc_tbl_q <= i_ftc_data[uifc_pkg::FTC_TBL_LO +: 2];
				ftc_sel_q <= i_ftc_data[uifc_pkg::FTC_TRGSEL];
			end
			if (i_trig_level_wr && !ftc_sel_q)
				rxp_q <= i_trig_level_data;
			if (i_trig_level_wr && ftc_sel_q)
				txp_q <= i_trig_level_data;
		end
	end

	assign trig.table_sel = tbl_q;
	assign trig.rx_field = rxf_q;
	assign trig.tx_field = txf_q;
	assign trig.rx_prog = rxp_q;
	assign trig.tx_prog = txp_q;

	// Sources
	logic line_src, rx_ready_src, modem_src;
	assign line_src = |i_line_status;
	assign rx_ready_src = fen_q ? (i_rx_count >= trig.rx_level) : (i_rx_count != 8'h00);
	assign modem_src = |i_modem_status;

	// Transmit ready: below trigger, or empty after a reload that never reached it
	logic tx_below, tx_over_q, tx_prev_below_q, tx_prev_empty_q, tx_ready_q;
	assign tx_below = i_tx_count < trig.tx_level;
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			tx_over_q <= 1'b0;
			tx_prev_below_q <= 1'b1;
			tx_prev_empty_q <= 1'b1;
			tx_ready_q <= 1'b0;
		end
		else
		begin
			tx_prev_below_q <= tx_below;
			tx_prev_empty_q <= (i_tx_count == 8'h00);
			if (i_tx_count == 8'h00)
				tx_over_q <= 1'b0;
			else if (!tx_below)
				tx_over_q <= 1'b1;
			if ((tx_below && !tx_prev_below_q && tx_over_q) ||
				(i_tx_count == 8'h00 && !tx_prev_empty_q && !tx_over_q))
				tx_ready_q <= 1'b1;
			else if (i_iss_rd || i_tx_holding_wr)
				tx_ready_q <= 1'b0;
		end
	end

	// Receive timeout timer
	uifc_pkg::uifc_to_state_t to_st_q;
	logic [7:0] to_cnt_q, to_limit;
	assign to_limit = 8'((uifc_pkg::TO_CHARS * int'(i_char_bits)) + uifc_pkg::TO_BITS);
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			to_st_q <= uifc_pkg::TO_IDLE;
			to_cnt_q <= 8'h00;
		end
		else
		begin
			case (to_st_q)
				uifc_pkg::TO_IDLE:
				begin
					to_cnt_q <= 8'h00;
					if (i_rx_char && fen_q)
						to_st_q <= uifc_pkg::TO_RUN;
				end
				uifc_pkg::TO_RUN:
				begin
					if (i_rx_count == 8'h00 || i_rx_char || i_rx_holding_rd)
						to_cnt_q <= 8'h00;
					else if (i_bit_tick)
						to_cnt_q <= to_cnt_q + 8'h01;
					if (i_rx_count == 8'h00)
						to_st_q <= uifc_pkg::TO_IDLE;
					else if (to_cnt_q >= to_limit)
						to_st_q <= uifc_pkg::TO_FIRED;
				end
				uifc_pkg::TO_FIRED:
				begin
					to_cnt_q <= 8'h00;
					if (i_rx_holding_rd)
						to_st_q <= (i_rx_count > 8'h01) ? uifc_pkg::TO_RUN : uifc_pkg::TO_IDLE;
				end
				default: to_st_q <= uifc_pkg::TO_IDLE;
			endcase
		end
	end

	// Sticky event sources, set wins over clear
	logic xo_q, sp_q, flow_q, wake_q, gpio_q, cts_d1_q, rts_d1_q;
	logic [GPIO_W-1:0] gpio_prev_q, gpio_act;
	assign gpio_act = (i_gpio ^ i_gpio_polarity_invert) & i_gpio_irq_enable;
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			xo_q <= 1'b0;
			sp_q <= 1'b0;
			flow_q <= 1'b0;
			wake_q <= 1'b0;
			gpio_q <= 1'b0;
			cts_d1_q <= 1'b0;
			rts_d1_q <= 1'b0;
			gpio_prev_q <= '0;
		end
		else
		begin
			cts_d1_q <= i_cts;
			rts_d1_q <= i_rts;
			gpio_prev_q <= gpio_act;
			if (i_xonoff_match)
				xo_q <= 1'b1;
			else if (i_iss_rd)
				xo_q <= 1'b0;
			if (i_special_match)
				sp_q <= 1'b1;
			else if (i_iss_rd || i_rx_char)
				sp_q <= 1'b0;
			if ((i_auto_cts && i_cts && !cts_d1_q) || (i_auto_rts && i_rts && !rts_d1_q))
				flow_q <= 1'b1;
			else if (i_modem_status_rd)
				flow_q <= 1'b0;
			if (i_wakeup && wake_en_q)
				wake_q <= 1'b1;
			else if (i_iss_rd)
				wake_q <= 1'b0;
			if (|(gpio_act & ~gpio_prev_q))
				gpio_q <= 1'b1;
			else if (i_gpio_lvl_rd)
				gpio_q <= 1'b0;
		end
	end

	// Priority encode and output registers
	logic [5:0] code;
	always_comb
	begin
		if (line_src) code = uifc_pkg::CODE_LINE;
		else if (to_st_q == uifc_pkg::TO_FIRED) code = uifc_pkg::CODE_RXTO;
		else if (rx_ready_src) code = uifc_pkg::CODE_RX_READY;
		else if (tx_ready_q) code = uifc_pkg::CODE_TX_READY;
		else if (modem_src) code = uifc_pkg::CODE_MODEM;
		else if ((xo_q || sp_q) && i_enh_features) code = uifc_pkg::CODE_CHAR;
		else if (flow_q && i_enh_features) code = uifc_pkg::CODE_FLOW;
		else code = uifc_pkg::CODE_NONE;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_interrupt_source_status <= 8'h01;
			o_irq_n <= 1'b1;
			o_fifo_en <= 1'b0;
			o_rx_fifo_rst <= 1'b0;
			o_tx_fifo_rst <= 1'b0;
			o_rx_trig_level <= 8'h01;
			o_tx_trig_level <= 8'h01;
		end
		else
		begin
			o_interrupt_source_status <= {fen_q, fen_q ^ gpio_q, code};
			o_irq_n <= code[0] && !gpio_q && !wake_q;
			o_fifo_en <= fen_q;
			o_rx_fifo_rst <= rst_rx_q;
			o_tx_fifo_rst <= rst_tx_q;
			o_rx_trig_level <= trig.rx_level;
			o_tx_trig_level <= trig.tx_level;
		end
	end

	a_line_code: assert property (@(posedge i_clk) disable iff (!i_nrst)
		line_src |=> o_interrupt_source_status[5:0] == uifc_pkg::CODE_LINE)
		else $error("line status not top");
	a_idle_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_interrupt_source_status[0] == ($past(code) == uifc_pkg::CODE_NONE))
		else $error("idle bit wrong");
	a_fifo_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_fsc_wr |=> ##1 o_interrupt_source_status[7] == $past(i_fsc_data[0], 2))
		else $error("fifo bit wrong");
	a_gpio_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
		gpio_q |=> o_interrupt_source_status[6] != o_interrupt_source_status[7])
		else $error("gpio bit wrong");
	a_rst_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_rx_fifo_rst |=> !o_rx_fifo_rst)
		else $error("reset not pulse");
	a_enh_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!$past(i_enh_features) |-> o_interrupt_source_status[5:4] == 2'h0)
		else $error("enhanced bits shown");
	a_flow_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
		flow_q && i_modem_status_rd && !i_cts && !i_rts |=> !flow_q)
		else $error("flow not cleared");
	a_fen_ignore: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_fsc_wr && !i_fsc_data[0] |=> $stable(rxf_q) && !rst_rx_q)
		else $error("bits taken without enable");
	a_wake_irq: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wake_q |=> !o_irq_n)
		else $error("wakeup not signalled");
endmodule

// File: dv/uifc_host_model.sv
// Host model issuing register strobes to the block
`timescale 1ns/1ps
module uifc_host_model
(
	input wire logic i_clk,
	output logic [3:0] o_wr,
	output logic [4:0] o_rd,
	output logic [7:0] o_data
);
	initial
	begin
		o_wr = 4'h0;
		o_rd = 5'h00;
		o_data = 8'h00;
	end
	// Strobe {rd, wr} for one edge, changed on falling edges
	task op(input logic [8:0] sel, input logic [7:0] d);
		@(negedge i_clk);
		{o_rd, o_wr} = sel;
		o_data = d;
		@(negedge i_clk);
		{o_rd, o_wr} = 9'h000;
	endtask
	task fsc_wr(input logic [7:0] d);
		op(9'h001, d | 8'h01);
	endtask
endmodule

// File: dv/uifc_top_tb_top.sv
// Self-checking bench for the interrupt and FIFO setup block
`timescale 1ns/1ps
module uifc_top_tb_top;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic enh = 1'b0, tick = 1'b0, rxc = 1'b0, xo = 1'b0, sp = 1'b0, wk = 1'b0;
	logic acts = 1'b0, arts = 1'b0, cts = 1'b0, rts = 1'b0;
	logic [4:1] ls = 4'h0;
	logic [3:0] ms = 4'h0, cb = 4'h8;
	logic [7:0] rxn = 8'h00, txn = 8'h00;
	logic [3:0] gp = 4'h0, ginv = 4'h0, gen = 4'h0;
	logic [3:0] wr;
	logic [4:0] rd;
	logic [7:0] d, st, rxl, txl, prx, ptx;
	logic irq_n, fen, rrst, trst;
	logic [1:0] rf, tf;
	int fail_count = 0, check_count = 0, i, k, tl;
	always #50 i_clk = ~i_clk;
	uifc_host_model host (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_data(d));
	uifc_top #(.GPIO_W(4)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_enh_features(enh),
		.i_fsc_wr(wr[0]), .i_fsc_data(d), .i_ftc_wr(wr[1]), .i_ftc_data(d),
		.i_trig_level_wr(wr[2]), .i_trig_level_data(d), .i_iss_rd(rd[0]),
		.i_line_status_rd(rd[1]), .i_modem_status_rd(rd[2]), .i_rx_holding_rd(rd[3]),
		.i_tx_holding_wr(wr[3]), .i_gpio_lvl_rd(rd[4]),
		.i_line_status(ls), .i_modem_status(ms), .i_rx_count(rxn), .i_tx_count(txn),
		.i_rx_char(rxc), .i_bit_tick(tick), .i_char_bits(cb), .i_xonoff_match(xo),
		.i_special_match(sp), .i_auto_cts(acts), .i_auto_rts(arts), .i_cts(cts),
		.i_rts(rts), .i_wakeup(wk), .i_gpio(gp), .i_gpio_polarity_invert(ginv),
		.i_gpio_irq_enable(gen), .o_interrupt_source_status(st), .o_irq_n(irq_n),
		.o_fifo_en(fen), .o_rx_fifo_rst(rrst), .o_tx_fifo_rst(trst),
		.o_rx_trig_level(rxl), .o_tx_trig_level(txl));
	function automatic logic [7:0] lvl(input int t, input bit tx, input logic [1:0] f);
		logic [7:0] a[4], b[4], c[4];
		a = '{8'h01, 8'h04, 8'h08, 8'h0e};
		if (tx)
		begin
			b = '{8'h10, 8'h08, 8'h18, 8'h1e};
			c = '{8'h08, 8'h10, 8'h20, 8'h38};
		end
		else
		begin
			b = '{8'h08, 8'h10, 8'h18, 8'h1c};
			c = '{8'h08, 8'h10, 8'h38, 8'h3c};
		end
		if (t == 0)
			return tx ? 8'h01 : a[f];
		if (t == 1)
			return b[f];
		if (t == 2)
			return c[f];
		return tx ? ptx : prx;
	endfunction
	task stop_test;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk8(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %0t got %h expected %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk8({7'h0, g}, {7'h0, e});
	endtask
	task w(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Status byte with FIFOs on and no GPIO event
	task sts(input logic [5:0] code);
		w(3);
		chk8(st, {2'b11, code});
	endtask
	initial
	begin
		#(100 * 20000);
		fail_count++;
		stop_test;
	end
	initial
	begin
		void'($urandom(32'h4446e4fc));
		w(12);
		i_nrst = 1'b1;
		chk8(st, 8'h01);
		chk1(irq_n, 1'b1);
		chk1(fen, 1'b0);
		enh = 1'b1;
		host.fsc_wr(8'h06);
		for (i = 0; i < 4 && rrst !== 1'b1; i++)
			w(1);
		chk1(rrst, 1'b1);
		chk1(trst, 1'b1);
		w(1);
		chk1(rrst, 1'b0);
		chk1(trst, 1'b0);
		chk8(st, 8'hc1);
		for (k = 0; k < 4; k++)
		begin
			rf = 2'($urandom);
			tf = 2'($urandom);
			prx = 8'($urandom_range(2, 100));
			ptx = 8'($urandom_range(2, 100));
			host.op(9'h002, 8'(k << 4));
			host.op(9'h004, prx);
			host.op(9'h002, 8'(k << 4) | 8'h80);
			host.op(9'h004, ptx);
			host.fsc_wr({rf, tf, 4'h1});
			w(3);
			chk8(rxl, lvl(k, 0, rf));
			chk8(txl, lvl(k, 1, tf));
		end
		host.op(9'h001, 8'h40);
		w(3);
		chk1(fen, 1'b0);
		chk8(rxl, prx);
		host.op(9'h002, 8'h00);
		host.fsc_wr(8'h40);
		rxn = 8'h04;
		sts(6'h04);
		rxn = 8'h03;
		sts(6'h01);
		rxn = 8'h00;
		ls = 4'h1 << $urandom_range(0, 3);
		ms = 4'h1 << $urandom_range(0, 3);
		sts(6'h06);
		chk1(irq_n, 1'b0);
		ls = 4'h0;
		host.op(9'h020, 8'h00);
		sts(6'h00);
		ms = 4'h0;
		host.op(9'h040, 8'h00);
		sts(6'h01);
		for (k = 0; k < 2; k++)
		begin
			txn = 8'h05;
			w(2);
			txn = 8'h00;
			sts(6'h02);
			host.op(k ? 9'h008 : 9'h010, 8'h00);
			sts(6'h01);
		end
		cb = 4'($urandom_range(5, 8));
		tl = 4 * int'(cb) + 12;
		rxn = 8'h01;
		tick = 1'b1;
		rxc = 1'b1;
		w(1);
		rxc = 1'b0;
		w(tl + 1);
		chk8(st, 8'hc1);
		w(1);
		chk8(st, 8'hcc);
		host.op(9'h080, 8'h00);
		w(1);
		chk8(st, 8'hc1);
		tick = 1'b0;
		rxn = 8'h00;
		host.fsc_wr(8'h48);
		wk = 1'b1;
		w(1);
		wk = 1'b0;
		w(2);
		chk1(irq_n, 1'b0);
		chk8(st, 8'hc1);
		host.op(9'h010, 8'h00);
		w(2);
		chk1(irq_n, 1'b1);
		enh = 1'b0;
		xo = 1'b1;
		w(1);
		xo = 1'b0;
		sts(6'h01);
		enh = 1'b1;
		sts(6'h10);
		host.op(9'h010, 8'h00);
		sts(6'h01);
		sp = 1'b1;
		w(1);
		sp = 1'b0;
		sts(6'h10);
		rxc = 1'b1;
		w(1);
		rxc = 1'b0;
		sts(6'h01);
		for (k = 0; k < 2; k++)
		begin
			{acts, arts} = k ? 2'b01 : 2'b10;
			w(2);
			{cts, rts} = {acts, arts};
			sts(6'h20);
			{cts, rts} = 2'b00;
			host.op(9'h040, 8'h00);
			sts(6'h01);
		end
		i = $urandom_range(0, 3);
		ginv = 4'($urandom);
		gp = ginv;
		gen = 4'h1 << i;
		w(2);
		gp[i] = ~ginv[i];
		w(3);
		chk8({6'h00, st[7:6]}, 8'h02);
		gp = ginv;
		host.op(9'h100 >> 0, 8'h00);
		host.op(9'h000 | (9'h1 << 8), 8'h00);
		w(3);
		chk8({6'h00, st[7:6]}, 8'h03);
		stop_test;
	end
endmodule
